/* File: design/hpt_top.sv */
// Purpose: Process trigger, standby and fault protection of a haptic driver
// Assumes: Faults, supply level and engine events arrive on sys_clk_i
// Notes:   Serial bus pins and the multi-purpose pin are synchronised
`include "hpt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hpt_top import hpt_pkg::*; #(
	parameter int         WDOG_CYCLES = `HPT_WDOG_CYCLES,
	parameter logic [6:0] BUS_ADDR    = 7'h2c, // Arbitrary
	parameter logic [3:0] PART_ID     = 4'h3,  // Arbitrary
	parameter logic [3:0] SILICON_REV = 4'h1   // Arbitrary
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       shutdown_pin_n_i,
	input  wire logic       i2c_scl_i,
	input  wire logic       i2c_sda_i,
	output logic            i2c_sda_o,
	output logic            i2c_sda_oe_o,
	input  wire logic       multi_purpose_pin_i,
	output logic            multi_purpose_pin_o,
	output logic            multi_purpose_pin_oe_o,
	input  wire logic       overcurrent_i,
	input  wire logic       thermal_i,
	input  wire logic       undervoltage_i,
	input  wire logic [7:0] supply_level_i,
	input  wire logic       drive_cycle_i,
	input  wire logic       process_done_i,
	input  wire logic       brake_done_i,
	output logic            process_active_o,
	output logic [1:0]      process_mode_o,
	output logic            brake_o,
	output logic            result_valid_o,
	output logic [7:0]      drive_level_o,
	output logic            resonance_track_o,
	output logic [7:0]      drive_period_o,
	output logic            actuator_type_o,
	output logic [2:0]      undervoltage_threshold_o,
	output logic [2:0]      calibration_duration_o
);
	// ==========================================================
	// Declarations
	logic [3:0]   s1_reg, s2_reg, s3_reg; // Pin synchronisers
	logic [3:0]   flt_reg;                // Agreed levels
	logic [3:0]   flt_d_reg;              // Agreed levels, one cycle old
	logic         asleep;                 // Shutdown pin held low
	logic         scl_rise, scl_fall;     // Clock edges
	logic         bus_start, bus_stop;    // Start and stop
	logic         pin_rise, pin_fall;     // Pin edges
	hpt_bus_type  bus_reg;                // Bus state
	logic [3:0]   bit_reg;                // Bit count
	logic [7:0]   sh_reg;                 // Receive shift
	logic [7:0]   tx_reg;                 // Transmit shift
	logic [7:0]   ptr_reg;                // Register pointer
	logic         first_reg;              // Next byte is pointer
	logic         rw_reg;                 // Read transfer
	logic         sda_oe_reg;             // Pulling data low
	logic [19:0]  wdog_reg;               // Stall counter
	logic         wr_stb, rd_stb;         // Register access strobes
	logic [7:0]   rd_data;                // Read multiplexer
	logic [7:0]   ctrl_reg;               // Mode, pin, brake, type, loop
	logic [3:0]   mask_reg;               // Interrupt masks
	logic [7:0]   period_reg;             // Open loop period
	logic [7:0]   levels_reg;             // Thresholds
	logic [7:0]   supply_reg;             // Supply reading
	logic [3:0]   status_reg;             // Sticky flags
	logic [3:0]   status_set;             // Flags raised now
	logic         pin_oe_reg;             // Interrupt drive
	logic [7:0]   level_reg;              // Drive level
	hpt_proc_type proc_reg;               // Process state
	hpt_mode_type run_mode_reg;           // Mode taken at start
	logic         result_reg;             // Result pulse
	logic         start_trig, stop_trig;  // Decoded triggers
	logic         fault;                  // Any fault while running or braking
	hpt_mode_type mode;                   // Current mode field
	hpt_pin_type  pin_fn;                 // Current pin function
	hpt_fifo_if #(.WIDTH(8)) amp_if ();   // Amplitude path

	assign asleep    = !flt_reg[3];
	assign scl_rise  = flt_reg[0] && !flt_d_reg[0];
	assign scl_fall  = !flt_reg[0] && flt_d_reg[0];
	assign bus_start = flt_reg[0] && flt_d_reg[0] && flt_d_reg[1] && !flt_reg[1];
	assign bus_stop  = flt_reg[0] && flt_d_reg[0] && !flt_d_reg[1] && flt_reg[1];
	assign pin_rise  = flt_reg[2] && !flt_d_reg[2];
	assign pin_fall  = !flt_reg[2] && flt_d_reg[2];
	assign mode      = hpt_mode_type'(ctrl_reg[`HPT_CTRL_MODE_LSB +: 2]);
	assign pin_fn    = hpt_pin_type'(ctrl_reg[`HPT_CTRL_PIN_LSB +: 2]);

	// ==========================================================
	// Synchronisers: change counts once stages two and three agree
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg    <= `HPT_SYNC_RST;
			s2_reg    <= `HPT_SYNC_RST;
			s3_reg    <= `HPT_SYNC_RST;
			flt_reg   <= `HPT_SYNC_RST;
			flt_d_reg <= `HPT_SYNC_RST;
		end else begin
			s1_reg    <= {shutdown_pin_n_i, multi_purpose_pin_i, i2c_sda_i, i2c_scl_i};
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			flt_reg   <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
			flt_d_reg <= flt_reg;
		end
	end

	// ==========================================================
	// Serial bus slave
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_reg    <= S_IDLE;
			bit_reg    <= '0;
			sh_reg     <= '0;
			tx_reg     <= '0;
			ptr_reg    <= '0;
			first_reg  <= 1'b0;
			rw_reg     <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (asleep || bus_stop || (wdog_reg == 20'(WDOG_CYCLES))) begin
			bus_reg    <= S_IDLE;
			sda_oe_reg <= 1'b0;
			if (asleep) begin
				ptr_reg <= '0;
			end
		end else if (bus_start) begin
			bus_reg    <= S_ADDR;
			bit_reg    <= '0;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise) begin
			bit_reg <= 4'(bit_reg + 1'b1);
			sh_reg  <= {sh_reg[6:0], flt_reg[1]};
			if (bus_reg == S_RACK) begin
				rw_reg <= !flt_reg[1]; // Master ack keeps reading
			end
		end else if (scl_fall) begin
			case (bus_reg)
				S_ADDR: begin
					if (bit_reg == 4'h8) begin
						if (sh_reg[7:1] == BUS_ADDR) begin
							bus_reg    <= S_AACK;
							rw_reg     <= sh_reg[0];
							sda_oe_reg <= 1'b1;
						end else begin
							bus_reg <= S_IDLE;
						end
					end
				end
				S_AACK, S_RACK: begin
					bit_reg <= '0;
					if (rw_reg) begin
						bus_reg    <= S_RDATA;
						tx_reg     <= {rd_data[6:0], 1'b0};
						sda_oe_reg <= !rd_data[7];
						ptr_reg    <= 8'(ptr_reg + 1'b1);
					end else if (bus_reg == S_AACK) begin
						bus_reg    <= S_WDATA;
						first_reg  <= 1'b1;
						sda_oe_reg <= 1'b0;
					end else begin
						bus_reg    <= S_IDLE;
						sda_oe_reg <= 1'b0;
					end
				end
				S_WDATA: begin
					if (bit_reg == 4'h8) begin
						bus_reg   <= S_WACK;
						first_reg <= 1'b0;
						// Full amplitude FIFO refuses the byte
						sda_oe_reg <= !(wr_stb && (ptr_reg == `HPT_REG_AMP) && !amp_if.push_ready);
						if (first_reg) begin
							ptr_reg <= sh_reg;
						end else begin
							ptr_reg <= 8'(ptr_reg + 1'b1);
						end
					end
				end
				S_WACK: begin
					bus_reg    <= S_WDATA;
					bit_reg    <= '0;
					sda_oe_reg <= 1'b0;
				end
				S_RDATA: begin
					if (bit_reg == 4'h8) begin
						bus_reg    <= S_RACK;
						sda_oe_reg <= 1'b0;
					end else begin
						tx_reg     <= {tx_reg[6:0], 1'b0};
						sda_oe_reg <= !tx_reg[7];
					end
				end
				default: bus_reg <= S_IDLE;
			endcase
		end
	end

	// Stall watchdog, cleared by any clock edge or idle bus
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wdog_reg <= '0;
		end else if ((bus_reg == S_IDLE) || scl_rise || scl_fall) begin
			wdog_reg <= '0;
		end else begin
			wdog_reg <= 20'(wdog_reg + 1'b1);
		end
	end

	assign wr_stb = scl_fall && (bus_reg == S_WDATA) && (bit_reg == 4'h8) && !first_reg;
	assign rd_stb = scl_fall && rw_reg && ((bus_reg == S_AACK) || (bus_reg == S_RACK));
	assign i2c_sda_o    = 1'b0;
	assign i2c_sda_oe_o = sda_oe_reg;

	// ==========================================================
	// Register read multiplexer
	always_comb begin
		if (ptr_reg == `HPT_REG_ID) begin
			rd_data = {PART_ID, SILICON_REV};
		end else if (ptr_reg == `HPT_REG_STATUS) begin
			rd_data = {4'h0, status_reg};
		end else if (ptr_reg == `HPT_REG_CTRL) begin
			rd_data = ctrl_reg;
		end else if (ptr_reg == `HPT_REG_GO) begin
			rd_data = {7'h00, proc_reg != P_STANDBY};
		end else if (ptr_reg == `HPT_REG_MASK) begin
			rd_data = {4'h0, mask_reg};
		end else if (ptr_reg == `HPT_REG_AMP) begin
			rd_data = level_reg;
		end else if (ptr_reg == `HPT_REG_PERIOD) begin
			rd_data = period_reg;
		end else if (ptr_reg == `HPT_REG_LEVELS) begin
			rd_data = levels_reg;
		end else if (ptr_reg == `HPT_REG_SUPPLY) begin
			rd_data = supply_reg;
		end else begin
			rd_data = 8'h00;
		end
	end

	// Writable configuration, defaults again while asleep
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_reg   <= `HPT_CTRL_RST;
			mask_reg   <= `HPT_MASK_RST;
			period_reg <= `HPT_PERIOD_RST;
			levels_reg <= `HPT_LEVELS_RST;
		end else if (asleep) begin
			ctrl_reg   <= `HPT_CTRL_RST;
			mask_reg   <= `HPT_MASK_RST;
			period_reg <= `HPT_PERIOD_RST;
			levels_reg <= `HPT_LEVELS_RST;
		end else if (wr_stb) begin
			if (ptr_reg == `HPT_REG_CTRL) begin
				ctrl_reg <= sh_reg;
			end else if (ptr_reg == `HPT_REG_MASK) begin
				mask_reg <= sh_reg[3:0];
			end else if (ptr_reg == `HPT_REG_PERIOD) begin
				period_reg <= sh_reg;
			end else if (ptr_reg == `HPT_REG_LEVELS) begin
				levels_reg <= sh_reg;
			end
		end
	end

	// ==========================================================
	// Amplitude FIFO
	assign amp_if.flush      = asleep;
	assign amp_if.push_valid = wr_stb && (ptr_reg == `HPT_REG_AMP);
	assign amp_if.push_data  = sh_reg;
	assign amp_if.pop_ready  = (proc_reg == P_RUN) && (run_mode_reg == MODE_RT) && drive_cycle_i;

	hpt_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.port_i    (amp_if)
	);

	// Drive level holds the last amplitude taken
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_reg <= '0;
		end else if (asleep) begin
			level_reg <= '0;
		end else if (amp_if.pop_ready && amp_if.pop_valid) begin
			level_reg <= amp_if.pop_data;
		end
	end

	// Supply reading on every drive cycle while playing
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			supply_reg <= '0;
		end else if (asleep) begin
			supply_reg <= '0;
		end else if ((proc_reg == P_RUN) && drive_cycle_i) begin
			supply_reg <= supply_level_i;
		end
	end

	// ==========================================================
	// Triggers: one pin function at a time
	always_comb begin
		start_trig = wr_stb && (ptr_reg == `HPT_REG_GO) && sh_reg[0];
		stop_trig  = wr_stb && (ptr_reg == `HPT_REG_GO) && !sh_reg[0];
		if (pin_fn == PIN_EDGE) begin
			start_trig = start_trig || (pin_rise && (proc_reg == P_STANDBY));
			stop_trig  = stop_trig || (pin_rise && (proc_reg != P_STANDBY));
		end else if (pin_fn == PIN_LEVEL) begin
			start_trig = start_trig || pin_rise;
			stop_trig  = stop_trig || pin_fall;
		end
		fault = (proc_reg != P_STANDBY) && (overcurrent_i || thermal_i || undervoltage_i);
	end

	// ==========================================================
	// Process state
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			proc_reg     <= P_STANDBY;
			run_mode_reg <= MODE_RT;
			result_reg   <= 1'b0;
		end else if (asleep) begin
			proc_reg   <= P_STANDBY;
			result_reg <= 1'b0;
		end else begin
			result_reg <= 1'b0;
			case (proc_reg)
				P_STANDBY: begin
					if (start_trig) begin
						proc_reg     <= P_RUN;
						run_mode_reg <= mode;
					end
				end
				P_RUN: begin
					if (fault) begin
						proc_reg <= P_STANDBY;
					end else if ((run_mode_reg != MODE_RT) && process_done_i) begin
						proc_reg   <= P_STANDBY;
						result_reg <= 1'b1;
					end else if ((run_mode_reg == MODE_CAL) && stop_trig) begin
						proc_reg   <= P_STANDBY;
						result_reg <= (calibration_duration_o == `HPT_CAL_TRIG);
					end else if (stop_trig || ((run_mode_reg == MODE_RT) && (mode != MODE_RT))) begin
						proc_reg <= ctrl_reg[`HPT_CTRL_BRAKE] ? P_BRAKE : P_STANDBY;
					end
				end
				P_BRAKE: begin
					if (fault || brake_done_i) begin
						proc_reg <= P_STANDBY;
					end
				end
				default: proc_reg <= P_STANDBY;
			endcase
		end
	end

	// ==========================================================
	// Sticky status, a new event beats the read clear
	always_comb begin
		status_set = '0;
		status_set[`HPT_ST_OC]   = fault && overcurrent_i;
		status_set[`HPT_ST_TH]   = fault && thermal_i;
		status_set[`HPT_ST_UV]   = fault && undervoltage_i;
		status_set[`HPT_ST_DONE] = !fault && (proc_reg == P_RUN) && (run_mode_reg != MODE_RT)
			&& (process_done_i || (stop_trig && (run_mode_reg == MODE_CAL)
			&& (calibration_duration_o == `HPT_CAL_TRIG)));
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_reg <= '0;
		end else if (asleep) begin
			status_reg <= '0;
		end else if (rd_stb && (ptr_reg == `HPT_REG_STATUS)) begin
			status_reg <= status_set;
		end else begin
			status_reg <= status_reg | status_set;
		end
	end

	// Interrupt drive on the pin only in interrupt function
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_oe_reg <= 1'b0;
		end else begin
			pin_oe_reg <= !asleep && (pin_fn == PIN_IRQ)
				&& |(status_reg & ~mask_reg);
		end
	end

	// ==========================================================
	// Outputs
	assign multi_purpose_pin_o      = 1'b0;
	assign multi_purpose_pin_oe_o   = pin_oe_reg;
	assign process_active_o         = (proc_reg == P_RUN);
	assign process_mode_o           = run_mode_reg;
	assign brake_o                  = (proc_reg == P_BRAKE);
	assign result_valid_o           = result_reg;
	assign drive_level_o            = level_reg;
	assign actuator_type_o          = ctrl_reg[`HPT_CTRL_ACT];
	assign resonance_track_o        = !ctrl_reg[`HPT_CTRL_ACT] && !ctrl_reg[`HPT_CTRL_OPEN];
	assign drive_period_o           = period_reg;
	assign undervoltage_threshold_o = levels_reg[`HPT_LEV_UV_LSB +: 3];
	assign calibration_duration_o   = levels_reg[`HPT_LEV_CAL_LSB +: 3];
endmodule
`default_nettype wire

/* File: design/hpt_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers reached over the serial bus
// Notes:   Definitions only
`ifndef HPT_PARAMS_SVH
`define HPT_PARAMS_SVH

// ==========================================================
// Register offsets
`define HPT_REG_ID        8'h00
`define HPT_REG_STATUS    8'h01
`define HPT_REG_CTRL      8'h02
`define HPT_REG_GO        8'h03
`define HPT_REG_MASK      8'h04
`define HPT_REG_AMP       8'h05
`define HPT_REG_PERIOD    8'h06
`define HPT_REG_LEVELS    8'h07
`define HPT_REG_SUPPLY    8'h08

// ==========================================================
// Field positions
`define HPT_CTRL_MODE_LSB 0
`define HPT_CTRL_PIN_LSB  2
`define HPT_CTRL_BRAKE    4
`define HPT_CTRL_ACT      5
`define HPT_CTRL_OPEN     6
`define HPT_ST_OC         0
`define HPT_ST_TH         1
`define HPT_ST_UV         2
`define HPT_ST_DONE       3
`define HPT_LEV_UV_LSB    0
`define HPT_LEV_CAL_LSB   4

// ==========================================================
// Reset values and codes
`define HPT_CTRL_RST      8'h00
`define HPT_MASK_RST      4'h0
`define HPT_PERIOD_RST    8'h00
`define HPT_LEVELS_RST    8'h00
`define HPT_CAL_TRIG      3'h7
`define HPT_SYNC_RST      4'hb

// ==========================================================
// Timing
`define HPT_CLK_PERIOD_NS 5
`define HPT_WDOG_TIME_NS  4330000
`define HPT_WDOG_CYCLES   (`HPT_WDOG_TIME_NS / `HPT_CLK_PERIOD_NS)

`endif

/* File: design/hpt_pkg.sv */
// Purpose: Types shared by the trigger and protection logic
// Assumes: Nothing
// Notes:   Constants live in hpt_params.svh
package hpt_pkg;
	// Process selected by the mode field
	typedef enum logic [1:0] {MODE_RT = 2'b00, MODE_SEQ = 2'b01,
		MODE_DIAG = 2'b10, MODE_CAL = 2'b11} hpt_mode_type;
	// Multi-purpose pin function
	typedef enum logic [1:0] {PIN_EDGE = 2'b00, PIN_LEVEL = 2'b01,
		PIN_IRQ = 2'b10, PIN_OFF = 2'b11} hpt_pin_type;
	// Process state, Gray along standby, run, brake
	typedef enum logic [1:0] {P_STANDBY = 2'b00, P_RUN = 2'b01,
		P_BRAKE = 2'b11} hpt_proc_type;
	// Serial bus state, Gray along address, ack, data, ack
	typedef enum logic [2:0] {S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b011,
		S_WDATA = 3'b010, S_WACK = 3'b110, S_RDATA = 3'b111,
		S_RACK = 3'b101} hpt_bus_type;
endpackage

/* File: design/hpt_fifo_if.sv */
// Purpose: Carrier between amplitude writer and amplitude FIFO
// Assumes: One clock
// Notes:   Valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
interface hpt_fifo_if #(parameter int WIDTH = 8);
	logic             flush;      // Drop all words
	logic             push_valid; // Word offered
	logic             push_ready; // Room for a word
	logic [WIDTH-1:0] push_data;  // Word in
	logic             pop_valid;  // Head word present
	logic             pop_ready;  // Head word taken
	logic [WIDTH-1:0] pop_data;   // Head word, registered
	modport src (output flush, push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
	modport fifo (input flush, push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

/* File: design/hpt_fifo.sv */
// Purpose: Amplitude FIFO with registered head word
// Assumes: Push and pop on one clock
// Notes:   Honest full and empty, flush empties at once
`timescale 1ns/1ps
`default_nettype none
module hpt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	hpt_fifo_if.fifo  port_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage
	logic [AW-1:0]    wptr_reg;          // Write index
	logic [AW-1:0]    rptr_reg;          // Read index
	logic [AW-1:0]    rptr_next;         // Read index after pop
	logic [AW:0]      count_reg;         // Words held
	logic [AW:0]      count_next;        // Words after this cycle
	logic [WIDTH-1:0] head_reg;          // Registered head word
	logic             valid_reg;         // Head word present
	logic             push;              // Word accepted
	logic             pop;               // Word removed

	// ==========================================================
	// Handshake
	assign port_i.push_ready = (count_reg != (AW + 1)'(DEPTH));
	assign port_i.pop_valid  = valid_reg;
	assign port_i.pop_data   = head_reg;
	assign push = port_i.push_valid && port_i.push_ready;
	assign pop  = port_i.pop_ready && valid_reg;

	// Next read index and count
	always_comb begin
		rptr_next  = pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
		count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// ==========================================================
	// Storage write
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_reg[wptr_reg] <= port_i.push_data;
		end
	end

	// Pointers and count
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
			valid_reg <= 1'b0;
		end else if (port_i.flush) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			if (push) begin
				wptr_reg <= AW'(wptr_reg + 1'b1);
			end
			rptr_reg  <= rptr_next;
			count_reg <= count_next;
			valid_reg <= (count_next != '0);
		end
	end

	// Head word, bypass when written into the next read slot
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			head_reg <= '0;
		end else if (push && (wptr_reg == rptr_next)) begin
			head_reg <= port_i.push_data;
		end else begin
			head_reg <= mem_reg[rptr_next];
		end
	end
endmodule
`default_nettype wire

/* File: testbench/hpt_host.sv */
// Purpose: serial bus host model. Assumes: pull-up on data. Notes: bit-banged
`timescale 1ns/1ps
`default_nettype none
module hpt_host (
	input  wire logic sys_clk_i, // Bench clock
	input  wire logic sda_i,     // Resolved data wire
	output logic      scl_o,     // Bus clock, idles high
	output logic      sda_oe_o   // High pulls data low
);
	// ==== Bus phases
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// One phase: set both lines, hold them 20 clocks
	task automatic ph(input logic c, input logic d);
		scl_o = c;
		sda_oe_o = !d;
		repeat (20) @(negedge sys_clk_i);
	endtask
	// Byte out MSB first, ninth bit released; read bits sampled with clock high
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, i > 0 ? d[i-1] : 1'b1);
			ph(1'b1, i > 0 ? d[i-1] : 1'b1);
			if (i > 0)
				q[i-1] = sda_i;
			ph(1'b0, i > 0 ? d[i-1] : 1'b1);
		end
	endtask
	// Pointer then one data byte
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		ph(1'b1, 1'b0);
		xfer(8'h58, q);
		xfer(p, q);
		xfer(d, q);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	// Pointer, repeated start, one byte read, host declines more
	task automatic rd(input logic [7:0] p, output logic [7:0] q);
		ph(1'b1, 1'b0);
		xfer(8'h58, q);
		xfer(p, q);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		xfer(8'h59, q);
		xfer(8'hff, q);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
endmodule
`default_nettype wire

/* File: testbench/hpt_top_assertions.sv */
// Purpose: port checks. Assumes: one clock. Notes: bound to hpt_top
`timescale 1ns/1ps
`default_nettype none
module hpt_chk (
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       overcurrent_i,
	input wire logic       thermal_i,
	input wire logic       undervoltage_i,
	input wire logic       drive_cycle_i,
	input wire logic       process_active_o,
	input wire logic [1:0] process_mode_o,
	input wire logic       brake_o,
	input wire logic       result_valid_o,
	input wire logic [7:0] drive_level_o,
	input wire logic       resonance_track_o,
	input wire logic       actuator_type_o
);
	// ==== Properties
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	oc_stop_a: assert property (process_active_o && overcurrent_i
		|=> !process_active_o && !brake_o) else $error("overcurrent kept running");
	th_stop_a: assert property ((process_active_o || brake_o) && thermal_i
		|=> !process_active_o && !brake_o) else $error("thermal kept running");
	uv_stop_a: assert property (process_active_o && undervoltage_i
		|=> !process_active_o && !brake_o) else $error("droop kept running");
	level_hold_a: assert property (process_active_o && !drive_cycle_i
		|=> $stable(drive_level_o)) else $error("level moved without drive cycle");
	mode_hold_a: assert property (process_active_o && $past(process_active_o)
		|-> $stable(process_mode_o)) else $error("mode moved in run");
	result_src_a: assert property (result_valid_o
		|-> $past(process_active_o)) else $error("result without run");
	res_type_a: assert property (resonance_track_o
		|-> !actuator_type_o) else $error("tracking on wrong actuator");
	state_excl_a: assert property (!(brake_o && process_active_o))
		else $error("brake during run");
	cover property (result_valid_o);
	cover property ($fell(process_active_o) && !brake_o);
	cover property (process_active_o && drive_cycle_i);
	cover property (brake_o);
endmodule
bind hpt_top hpt_chk u_hpt_chk (.*);
`default_nettype wire

/* File: testbench/haptic_process_trigger_protect_tb.sv */
// Purpose: self-checking bench. Assumes: host model. Notes: short bus watchdog
`include "hpt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module haptic_process_trigger_protect_tb;
	logic       clk = 0, rst = 1, nsd_n = 1, pin = 0, dcy = 0, pdone = 0, bdone = 0;
	logic [2:0] flt = 0;   // Overcurrent, thermal, droop
	logic [7:0] sup = 0, q;
	wire        scl, hoe, soe, moe, act, brk, res, atyp, rv;
	wire  [1:0] pmode;
	wire  [2:0] uvt, cal;
	wire  [7:0] lvl, per;
	wire        sda = !(hoe || soe); // Pull-up data wire
	int         fail_count = 0, comparisons = 0, aq[$];
	int         rcount = 0; // Result pulses seen
	initial forever #2.5 clk = !clk;
	// Count one-cycle result pulses
	always @(posedge clk) begin
		if (rv)
			rcount <= rcount + 1;
	end
	hpt_host u_hpt_host (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(hoe));
	hpt_top #(.WDOG_CYCLES(200), .BUS_ADDR(7'h2c), .PART_ID(4'h3), .SILICON_REV(4'h1))
		u_hpt_top (.sys_clk_i(clk), .rst_i(rst),
		.shutdown_pin_n_i(nsd_n), .i2c_scl_i(scl), .i2c_sda_i(sda), .i2c_sda_o(),
		.i2c_sda_oe_o(soe), .multi_purpose_pin_i(pin), .multi_purpose_pin_o(),
		.multi_purpose_pin_oe_o(moe), .overcurrent_i(flt[0]), .thermal_i(flt[1]),
		.undervoltage_i(flt[2]), .supply_level_i(sup), .drive_cycle_i(dcy),
		.process_done_i(pdone), .brake_done_i(bdone), .process_active_o(act),
		.process_mode_o(pmode), .brake_o(brk), .result_valid_o(rv), .drive_level_o(lvl),
		.resonance_track_o(res), .drive_period_o(per), .actuator_type_o(atyp),
		.undervoltage_threshold_o(uvt), .calibration_duration_o(cal));
	// ==== Helpers
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s, input int n);
		s = 1;
		w(n);
		s = 0;
		w(2);
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==== Tests
	initial begin
		void'($urandom(32));
		w(4);
		rst = 0;
		w(8);
		chk(8'({atyp, res}), 8'h01);
		u_hpt_host.rd(8'h00, q);
		chk(q, 8'h31);
		aq.push_back($urandom_range(255));
		u_hpt_host.wr(8'h05, 8'(aq[0]));
		u_hpt_host.wr(8'h03, 8'h01);
		chk(8'(act), 8'h01);
		u_hpt_host.rd(8'h03, q);
		chk(q & 8'h01, 8'h01);
		sup = 8'($urandom);
		pulse(dcy, 1);
		chk(lvl, 8'(aq.pop_front()));
		u_hpt_host.rd(8'h08, q);
		chk(q, sup);
		$display("test realtime done");
		u_hpt_host.wr(8'h02, 8'h08);
		u_hpt_host.wr(8'h04, 8'h04);
		for (int i = 0; i < 3; i++) begin
			u_hpt_host.wr(8'h03, 8'h01);
			flt = 3'(1 << i);
			w(1);
			flt = 0;
			w(4);
			chk(8'(act), 8'h00);
			chk(8'(moe), 8'(i != 2));
			u_hpt_host.rd(8'h01, q);
			chk(q, 8'(1 << i));
			chk(8'(moe), 8'h00);
		end
		$display("test faults done");
		u_hpt_host.wr(8'h02, 8'h01);
		pulse(pin, 10);
		w(4);
		chk(8'(act), 8'h01);
		chk(8'(pmode), 8'h01);
		pulse(pdone, 1);
		chk(8'(act), 8'h00);
		chk(8'(moe), 8'h00);
		chk(8'(rcount), 8'h01);
		u_hpt_host.rd(8'h01, q);
		chk(q, 8'h08);
		pulse(pin, 10);
		pulse(pin, 10);
		w(4);
		chk(8'(act), 8'h00);
		u_hpt_host.rd(8'h01, q);
		chk(q, 8'h00);
		u_hpt_host.wr(8'h02, 8'h05);
		pin = 1;
		w(8);
		chk(8'(act), 8'h01);
		pin = 0;
		w(8);
		chk(8'(act), 8'h00);
		chk(8'(rcount), 8'h01);
		$display("test pin done");
		u_hpt_host.wr(8'h02, 8'h10);
		u_hpt_host.wr(8'h03, 8'h01);
		u_hpt_host.wr(8'h03, 8'h00);
		chk(8'(brk), 8'h01);
		pulse(bdone, 1);
		chk(8'({brk, act}), 8'h00);
		$display("test brake done");
		aq.push_back($urandom_range(255));
		u_hpt_host.wr(8'h06, 8'(aq[0]));
		u_hpt_host.wr(8'h07, 8'h75);
		u_hpt_host.wr(8'h02, 8'h40);
		chk(per, 8'(aq.pop_front()));
		chk(8'({cal, uvt}), 8'h3d);
		chk(8'({atyp, res}), 8'h00);
		$display("test config done");
		u_hpt_host.ph(1'b1, 1'b0);
		u_hpt_host.xfer(8'h58, q);
		w(250);
		u_hpt_host.xfer(8'h02, q);
		u_hpt_host.xfer(8'h01, q);
		u_hpt_host.ph(1'b1, 1'b1);
		u_hpt_host.rd(8'h02, q);
		chk(q, 8'h40);
		$display("test watchdog done");
		nsd_n = 0;
		w(10);
		nsd_n = 1;
		w(10);
		u_hpt_host.rd(8'h02, q);
		chk(q, `HPT_CTRL_RST);
		$display("test shutdown done");
		results();
	end
	initial begin
		w(90000);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
